// [include/acp_cfg.svh]
// Purpose: constants for the converter output and configuration port
// Assumes: included by bare name wherever a figure is needed
// Notes: serial word layout and register indexes are local choices
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

// ****************************************
// serial word layout
// ****************************************
`define ACP_WORD_BITS 16
`define ACP_HDR_BITS 8
`define ACP_RW_POS 15
`define ACP_ADDR_HI 14
`define ACP_ADDR_LO 8
`define ACP_NREGS 3

// ****************************************
// register indexes and fields
// ****************************************
`define ACP_IDX_POWER 7'h00
`define ACP_IDX_STAB 7'h01
`define ACP_IDX_FORMAT 7'h02
`define ACP_SLEEP_POS 0
`define ACP_STAB_EN_POS 0
`define ACP_DLY_LO 1
`define ACP_DLY_HI 2
`define ACP_FMT_LO 0
`define ACP_FMT_HI 1
`define ACP_CUR_LO 2
`define ACP_CUR_HI 4
`define ACP_TERM_POS 5
`define ACP_FMT_FULL 2'h0
`define ACP_FMT_DDR_CMOS 2'h1
`define ACP_FMT_DDR_LVDS 2'h2

// ****************************************
// reset values and fixed settings
// ****************************************
`define ACP_POWER_RST 8'h00
`define ACP_STAB_RST 8'h00
`define ACP_FORMAT_RST 8'h00
`define ACP_CUR_3P5MA 3'h0
`define ACP_DLY_MAX 4
`define ACP_STRAP_WAIT 2'h2

`endif

// [include/acp_pkg.sv]
// Purpose: shared types of the converter output and configuration port
// Assumes: nothing
// Notes: format enum is decoded from the format register field, or from the serial clock pin in parallel mode
package acp_pkg;
   typedef enum logic [1:0] {ACP_FULL_CMOS, ACP_DDR_CMOS, ACP_DDR_LVDS} acp_fmt_t;
endpackage

// [rtl/acp_sync2.sv]
// Purpose: two flip-flop level synchroniser, one per bit
// Assumes: inputs are levels that stay put for several destination clocks
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
module acp_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // levels
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   // two stages, no logic between them
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_r <= '0;
         q_out <= '0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // acp_sync2

// [rtl/acp_top.sv]
// Purpose: digital side of a 12-bit sampling converter: strap, serial or
//    parallel configuration, and the sample output formatter
// Assumes: encode pins toggle slower than a quarter of clk_sys_in
// Notes: serial shifting runs on the serial clock; settings cross by toggle
//
// Behaviour
// - strap low makes four pins a serial port; high makes three static inputs
// - conversion begins on encode positive rising, complement falling
// - serial clock shifts only while chip select is low
// - serial input bits are captured on rising serial clock edges
// - readback bits shift out on serial output, sampled on falling edge
// - serial output only pulls low or releases
// - parallel mode: chip select low disables stabilizer, high enables it
// - parallel mode: serial clock low full-rate CMOS, high DDR LVDS 3.5mA
// - parallel mode: serial input high puts device to sleep
// - parallel mode: serial output unused and left open
// - full-rate CMOS gives twelve bits per cycle, bit 11 most significant
// - full-rate data changes with the falling edge of the output clock
// - complementary output clock is always the inverse of the true one
// - output clock phase can be delayed by a register setting
// - range flag high for an out-of-range sample, low otherwise
// - DDR CMOS: six pins, even bit while clock low, odd while high
// - DDR modes change data on both output clock edges
// - DDR LVDS uses six pairs with the same bit ordering
// - LVDS drive current and 100 ohm termination set by configuration
// - DDR CMOS is selectable only through serial registers
// - serial mode takes output format from the format register
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_top import acp_pkg::*; (
   // system clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // strap and configuration pins
   input wire logic programming_select_strap_in,
   input wire logic spi_cs_b_in,
   input wire logic spi_sck_in,
   input wire logic spi_sdi_in,
   output logic spi_sdo_out,
   output logic spi_sdo_oe_out,
   // encode pins and converter core
   input wire logic encode_clock_pos_in,
   input wire logic encode_clock_neg_in,
   input wire logic [11:0] sample_code_in,
   input wire logic sample_over_in,
   output logic conv_start_out,
   // sample outputs
   output logic [11:0] sample_bits_out,
   output logic [5:0] paired_sample_bits_out,
   output logic range_exceeded_flag_out,
   output logic data_out_clock_true_out,
   output logic data_out_clock_comp_out,
   // analog controls
   output logic stabilizer_enable_out,
   output logic sleep_out,
   output logic lvds_enable_out,
   output logic [2:0] lvds_current_sel_out,
   output logic lvds_term_en_out
);

   // ****************************************
   // serial clock domain
   // ****************************************
   logic frame_rst_b;
   logic [`ACP_WORD_BITS-1:0] shift_r;
   logic [4:0] bit_cnt_r;
   logic [`ACP_WORD_BITS-1:0] word_in;
   logic [7:0] mirror_r [`ACP_NREGS];
   logic [6:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic wr_tgl_r;
   logic [7:0] rd_data_r;
   logic rd_act_r;
   logic sdo_low_r;
   logic word_done;
   logic hdr_done;
   logic [6:0] word_addr;
   // chip select high holds the frame logic in reset
   assign frame_rst_b = rst_b_in & ~spi_cs_b_in;
   assign word_in = {shift_r[`ACP_WORD_BITS-2:0], spi_sdi_in};
   assign word_addr = word_in[`ACP_ADDR_HI:`ACP_ADDR_LO];
   assign word_done = (bit_cnt_r == 5'(`ACP_WORD_BITS - 1));
   assign hdr_done = (bit_cnt_r == 5'(`ACP_HDR_BITS - 1));

   // shift in on rising edge, count saturates after one word
   always_ff @(posedge spi_sck_in or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         shift_r <= '0;
         bit_cnt_r <= '0;
      end else begin
         shift_r <= word_in;
         if (bit_cnt_r != 5'(`ACP_WORD_BITS)) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // commit only whole write words to a mapped index
   always_ff @(posedge spi_sck_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_addr_r <= '0;
         wr_data_r <= '0;
         wr_tgl_r <= 1'b0;
         mirror_r[0] <= `ACP_POWER_RST;
         mirror_r[1] <= `ACP_STAB_RST;
         mirror_r[2] <= `ACP_FORMAT_RST;
      end else if (!spi_cs_b_in && word_done && !word_in[`ACP_RW_POS]
                   && word_addr < 7'(`ACP_NREGS)) begin
         wr_addr_r <= word_addr;
         wr_data_r <= word_in[7:0];
         wr_tgl_r <= ~wr_tgl_r;
         mirror_r[word_addr[1:0]] <= word_in[7:0];
      end
   end

   // readback: load the addressed mirror once the header is in
   always_ff @(posedge spi_sck_in or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         rd_data_r <= '0;
         rd_act_r <= 1'b0;
      end else if (hdr_done && word_in[`ACP_HDR_BITS-1]) begin
         // header sits in the low byte of word_in at this edge
         rd_act_r <= (word_in[6:0] < 7'(`ACP_NREGS));
         rd_data_r <= (word_in[6:0] < 7'(`ACP_NREGS)) ? mirror_r[word_in[1:0]] : 8'h00;
      end
   end

   // drive on falling edge so the host samples on the next falling edge
   always_ff @(negedge spi_sck_in or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         sdo_low_r <= 1'b0;
      end else if (rd_act_r && bit_cnt_r >= 5'(`ACP_HDR_BITS)
                   && bit_cnt_r < 5'(`ACP_WORD_BITS)) begin
         sdo_low_r <= ~rd_data_r[3'(5'(`ACP_WORD_BITS - 1) - bit_cnt_r)];
      end else begin
         sdo_low_r <= 1'b0;
      end
   end

   // ****************************************
   // crossing into the system domain
   // ****************************************
   logic [6:0] pin_s;
   logic strap_s, cs_s, sck_s, sdi_s, enc_pos_s, enc_neg_s, wr_tgl_s;

   acp_sync2 #(.W(7)) u_sync (
      .clk_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .d_in({programming_select_strap_in, spi_cs_b_in, spi_sck_in, spi_sdi_in,
             encode_clock_pos_in, encode_clock_neg_in, wr_tgl_r}),
      .q_out(pin_s)
   );
   assign {strap_s, cs_s, sck_s, sdi_s, enc_pos_s, enc_neg_s, wr_tgl_s} = pin_s;
   // ****************************************
   // strap and control registers
   // ****************************************
   logic strap_r, strap_done_r, wr_tgl_d_r;
   logic [1:0] strap_wait_r;
   logic [7:0] power_r, stab_r, format_r;
   logic ser_mode;
   // strap caught once, after the synchroniser has flushed its reset value
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         strap_r <= 1'b1;
         strap_done_r <= 1'b0;
         strap_wait_r <= 2'h0;
      end else if (strap_wait_r != `ACP_STRAP_WAIT) begin
         strap_wait_r <= strap_wait_r + 2'h1; // sync stages still show reset value
      end else if (!strap_done_r) begin
         strap_r <= strap_s;
         strap_done_r <= 1'b1;
      end
   end
   assign ser_mode = strap_done_r & ~strap_r;
   // toggle edge means the serial side holds a settled address and data
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_tgl_d_r <= 1'b0;
         power_r <= `ACP_POWER_RST;
         stab_r <= `ACP_STAB_RST;
         format_r <= `ACP_FORMAT_RST;
      end else begin
         wr_tgl_d_r <= wr_tgl_s;
         if ((wr_tgl_s ^ wr_tgl_d_r) && ser_mode) begin
            if (wr_addr_r == `ACP_IDX_POWER) power_r <= wr_data_r;
            if (wr_addr_r == `ACP_IDX_STAB) stab_r <= wr_data_r;
            if (wr_addr_r == `ACP_IDX_FORMAT) format_r <= wr_data_r;
         end
      end
   end

   // ****************************************
   // effective settings
   // ****************************************
   acp_fmt_t fmt_nxt, fmt_r;
   logic [1:0] dly_nxt, dly_r;

   always_comb begin
      fmt_nxt = ACP_FULL_CMOS;
      if (ser_mode) begin
         case (format_r[`ACP_FMT_HI:`ACP_FMT_LO])
            `ACP_FMT_DDR_CMOS: fmt_nxt = ACP_DDR_CMOS;
            `ACP_FMT_DDR_LVDS: fmt_nxt = ACP_DDR_LVDS;
            default: fmt_nxt = ACP_FULL_CMOS;
         endcase
      end else if (sck_s) begin
         fmt_nxt = ACP_DDR_LVDS;
      end
      dly_nxt = ser_mode ? stab_r[`ACP_DLY_HI:`ACP_DLY_LO] : 2'h0;
   end

   // settings registered, parallel pins read as static levels
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fmt_r <= ACP_FULL_CMOS;
         dly_r <= 2'h0;
         stabilizer_enable_out <= 1'b0;
         sleep_out <= 1'b0;
         lvds_enable_out <= 1'b0;
         lvds_current_sel_out <= `ACP_CUR_3P5MA;
         lvds_term_en_out <= 1'b0;
      end else begin
         fmt_r <= fmt_nxt;
         dly_r <= dly_nxt;
         stabilizer_enable_out <= ser_mode ? stab_r[`ACP_STAB_EN_POS] : cs_s;
         sleep_out <= ser_mode ? power_r[`ACP_SLEEP_POS] : sdi_s;
         lvds_enable_out <= (fmt_nxt == ACP_DDR_LVDS);
         lvds_current_sel_out <= ser_mode ? format_r[`ACP_CUR_HI:`ACP_CUR_LO]
                                          : `ACP_CUR_3P5MA;
         lvds_term_en_out <= ser_mode & format_r[`ACP_TERM_POS];
      end
   end

   // open drain: only ever pulls low, never in parallel mode
   assign spi_sdo_out = 1'b0;
   assign spi_sdo_oe_out = sdo_low_r & ser_mode;

   // ****************************************
   // encode edges and sample formatter
   // ****************************************
   logic enc_lvl, enc_d_r, enc_rise, enc_fall;
   logic [11:0] word_r;
   logic [5:0] even_bits, odd_bits;
   logic phase_nxt, phase_r;
   logic [`ACP_DLY_MAX-1:0] dly_sh_r;
   logic clk_sel;

   // complement falling is the same instant as positive rising
   assign enc_lvl = enc_pos_s & ~enc_neg_s;
   assign enc_rise = enc_lvl & ~enc_d_r;
   assign enc_fall = ~enc_lvl & enc_d_r;

   // split the held word into even and odd lanes
   for (genvar i = 0; i < 6; i++) begin : g_pair
      assign even_bits[i] = word_r[2*i];
      assign odd_bits[i] = word_r[2*i+1];
   end

   // clock low after a new sample, high after the encode falls
   always_comb begin
      phase_nxt = phase_r;
      if (enc_rise && !sleep_out) phase_nxt = 1'b0;
      else if (enc_fall) phase_nxt = 1'b1;
   end

   // edge detect and sample capture
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         enc_d_r <= 1'b0;
         word_r <= '0;
         phase_r <= 1'b1;
         conv_start_out <= 1'b0;
         range_exceeded_flag_out <= 1'b0;
      end else begin
         enc_d_r <= enc_lvl;
         phase_r <= phase_nxt;
         conv_start_out <= enc_rise & ~sleep_out;
         if (enc_rise && !sleep_out) begin
            word_r <= sample_code_in;
            range_exceeded_flag_out <= sample_over_in;
         end
      end
   end

   // data pins follow the format; DDR lanes move on both phases
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sample_bits_out <= '0;
         paired_sample_bits_out <= '0;
      end else begin
         if (fmt_r == ACP_FULL_CMOS) begin
            if (enc_rise && !sleep_out) sample_bits_out <= sample_code_in;
            paired_sample_bits_out <= '0;
         end else begin
            sample_bits_out <= '0;
            // even lane while clock low, odd lane while high
            if (enc_rise && !sleep_out) begin
               for (int k = 0; k < 6; k++) begin
                  paired_sample_bits_out[k] <= sample_code_in[2*k];
               end
            end else if (enc_fall) begin
               paired_sample_bits_out <= odd_bits;
            end else if (!phase_r) begin
               paired_sample_bits_out <= even_bits;
            end
         end
      end
   end

   // output clock delay line; tap zero lines up with the data
   always_comb begin
      clk_sel = phase_nxt;
      if (dly_r != 2'h0) clk_sel = dly_sh_r[dly_r - 2'h1];
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dly_sh_r <= '1;
         data_out_clock_true_out <= 1'b1;
         data_out_clock_comp_out <= 1'b0;
      end else begin
         dly_sh_r <= {dly_sh_r[`ACP_DLY_MAX-2:0], phase_nxt};
         data_out_clock_true_out <= clk_sel;
         data_out_clock_comp_out <= ~clk_sel;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   a_clock_inverse: assert property (
      data_out_clock_comp_out == ~data_out_clock_true_out)
      else $error("output clock pair not complementary");
   a_start_on_rise: assert property (
      enc_rise && !sleep_out |=> conv_start_out && (!data_out_clock_true_out || dly_r != 2'h0))
      else $error("encode rise did not start a conversion");
   a_flag_follows: assert property (
      enc_rise && !sleep_out |=> range_exceeded_flag_out == $past(sample_over_in))
      else $error("range flag does not match sample");
   a_full_data_msb: assert property (
      enc_rise && !sleep_out && fmt_r == ACP_FULL_CMOS |=> sample_bits_out[11] == $past(sample_code_in[11]))
      else $error("full rate word not presented");
   a_ddr_odd_high: assert property (
      fmt_r != ACP_FULL_CMOS && fmt_nxt == fmt_r && enc_fall && dly_r == 2'h0
      |=> data_out_clock_true_out && paired_sample_bits_out == odd_bits)
      else $error("odd bits not shown while clock high");
   a_par_dcs: assert property (
      !ser_mode && strap_done_r ##1 !ser_mode |-> stabilizer_enable_out == $past(cs_s))
      else $error("stabilizer does not follow chip select");
   a_par_sleep: assert property (
      !ser_mode && strap_done_r ##1 !ser_mode |-> sleep_out == $past(sdi_s))
      else $error("sleep does not follow serial input pin");
   a_par_no_ddr_cmos: assert property (
      !ser_mode |-> fmt_nxt != ACP_DDR_CMOS)
      else $error("parallel mode chose double rate cmos");
   a_par_lvds_cur: assert property (
      !ser_mode && sck_s ##1 !ser_mode |-> lvds_enable_out && lvds_current_sel_out == `ACP_CUR_3P5MA)
      else $error("parallel lvds selection wrong");
   a_sdo_parallel: assert property (
      !ser_mode |-> !spi_sdo_oe_out)
      else $error("serial output driven in parallel mode");
   a_sleep_no_start: assert property (
      sleep_out |=> !conv_start_out)
      else $error("conversion started while asleep");
endmodule // acp_top

// [tb/acp_host_model.sv]
// Purpose: configuration host and pull-up model for the four config pins
// Assumes: serial clock period 30 ns, idle low, running only inside frames
// Notes: the bench calls the tasks hierarchically
`timescale 1ns/1ps
// ****************************************
// host model
// ****************************************
module acp_host_model (
   // pins toward the block
   output logic spi_cs_b_out,
   output logic spi_sck_out,
   output logic spi_sdi_out,
   // open-drain readback
   input wire logic spi_sdo_in,
   input wire logic spi_sdo_oe_in
);
   logic sdo_line;

   // external pull-up: a released line reads high
   assign sdo_line = spi_sdo_oe_in ? spi_sdo_in : 1'b1;

   // idle pins at time zero
   initial begin
      spi_cs_b_out = 1'b1;
      spi_sck_out = 1'b0;
      spi_sdi_out = 1'b0;
   end

   // one framed transfer, msb first; nb below 16 makes a partial frame
   task automatic xfer(input logic [15:0] w, input int nb, output logic [7:0] rd);
      rd = 8'h00;
      spi_cs_b_out = 1'b0;
      #15;
      for (int i = 0; i < nb; i++) begin
         spi_sdi_out = w[15-i];
         #15 spi_sck_out = 1'b1; // bit held across the rise
         #15;
         if (i >= 8) rd = {rd[6:0], sdo_line}; // taken at the fall
         spi_sck_out = 1'b0;
      end
      #15 spi_cs_b_out = 1'b1;
      spi_sdi_out = ~spi_sdi_out; // released data must not look held
      #300; // spacing between writes
   endtask

   // static levels for parallel mode
   task automatic set_par(input logic c, input logic k, input logic d);
      spi_cs_b_out = c;
      spi_sck_out = k;
      spi_sdi_out = d;
   endtask
endmodule // acp_host_model

// [tb/acp_top_tb.sv]
// Purpose: self-checking bench for the converter output and config port
// Assumes: strap moves only while reset is held
// Notes: samples are noted in a queue and matched at each start pulse
`timescale 1ns/1ps
`include "acp_cfg.svh"
// ****************************************
// bench top
// ****************************************
module acp_top_tb;
   logic clk_sys, rst_b, strap, enc_pos, enc_neg, over, prev_t;
   logic cs_b, sck, sdi, sdo, sdo_oe, conv_start, flag, clk_t, clk_c;
   logic stab, sleep, lvds, term;
   logic [11:0] code, sbits;
   logic [5:0] pbits;
   logic [2:0] cur;
   logic [7:0] fb, rd_d;
   logic [31:0] lfsr;
   logic [12:0] expq[$];
   logic [12:0] last;
   logic [1:0] exp_fmt;
   int fail_count, n_checks;
   int exp_dly;
   logic [3:0] st_hist;

   // 40 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   acp_top DUT (
      .clk_sys_in(clk_sys),
      .rst_b_in(rst_b),
      .programming_select_strap_in(strap),
      .spi_cs_b_in(cs_b),
      .spi_sck_in(sck),
      .spi_sdi_in(sdi),
      .spi_sdo_out(sdo),
      .spi_sdo_oe_out(sdo_oe),
      .encode_clock_pos_in(enc_pos),
      .encode_clock_neg_in(enc_neg),
      .sample_code_in(code),
      .sample_over_in(over),
      .conv_start_out(conv_start),
      .sample_bits_out(sbits),
      .paired_sample_bits_out(pbits),
      .range_exceeded_flag_out(flag),
      .data_out_clock_true_out(clk_t),
      .data_out_clock_comp_out(clk_c),
      .stabilizer_enable_out(stab),
      .sleep_out(sleep),
      .lvds_enable_out(lvds),
      .lvds_current_sel_out(cur),
      .lvds_term_en_out(term)
   );

   acp_host_model host (
      .spi_cs_b_out(cs_b),
      .spi_sck_out(sck),
      .spi_sdi_out(sdi),
      .spi_sdo_in(sdo),
      .spi_sdo_oe_in(sdo_oe)
   );

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [5:0] lanes(input logic [11:0] c, input int odd);
      logic [5:0] l;
      for (int k = 0; k < 6; k++) l[k] = c[2*k+odd];
      return l;
   endfunction

   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one encode period; a note is queued only when a start is due
   task automatic enc_cycle(input logic due);
      @(posedge clk_sys);
      lfsr = lfsr_next(lfsr);
      code <= lfsr[11:0];
      over <= lfsr[12];
      enc_pos <= 1'b1;
      enc_neg <= 1'b0;
      if (due) expq.push_back(lfsr[12:0]);
      repeat (4) @(posedge clk_sys);
      enc_pos <= 1'b0;
      enc_neg <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] rd;
      host.xfer({1'b0, a, d}, 16, rd);
      repeat (10) @(posedge clk_sys);
   endtask

   task automatic rdchk(input string nm, input logic [6:0] a, input logic [7:0] e);
      logic [7:0] rd;
      host.xfer({1'b1, a, 8'h00}, 16, rd);
      chk(nm, {4'h0, e}, {4'h0, rd});
   endtask

   task automatic do_reset(input logic s);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      strap <= s; // strap held fixed outside reset
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (10) @(posedge clk_sys);
   endtask

   // output watcher: oldest note against each start, odd lanes at the rise
   always @(negedge clk_sys) begin
      if (rst_b === 1'b1) begin
         chk("clock comp", {11'h0, ~clk_t}, {11'h0, clk_c});
         if (conv_start === 1'b1) begin
            if (expq.size() == 0) chk("start", 12'h0, 12'h1);
            else begin
               last = expq.pop_front();
               chk("flag", {11'h0, last[12]}, {11'h0, flag});
               chk("clock at start", {11'h0, exp_dly != 0}, {11'h0, clk_t});
               if (exp_fmt == 2'h1 || exp_fmt == 2'h2)
                  chk("even", {6'h0, lanes(last[11:0], 0)}, {6'h0, pbits});
               else chk("word", last[11:0], sbits);
            end
         end
         // output clock must fall exactly the programmed delay after the start
         st_hist = {st_hist[2:0], conv_start === 1'b1};
         if (st_hist[exp_dly] === 1'b1) chk("clock delayed", 12'h0, {11'h0, clk_t});
         if (clk_t === 1'b1 && prev_t === 1'b0 && (exp_fmt == 2'h1 || exp_fmt == 2'h2))
            chk("odd", {6'h0, lanes(last[11:0], 1)}, {6'h0, pbits});
         prev_t = clk_t;
      end
   end

   // cuts a hang short; the run needs well under 100 us
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end

   // main sequence: serial mode first, then parallel mode
   initial begin
      rst_b = 1'b0;
      strap = 1'b0;
      enc_pos = 1'b0;
      enc_neg = 1'b1;
      code = 12'h000;
      over = 1'b0;
      lfsr = 32'hF3B0E8B3;
      exp_fmt = 2'h0;
      prev_t = 1'b0;
      last = 13'h0000;
      exp_dly = 0;
      st_hist = 4'h0;
      fail_count = 0;
      n_checks = 0;
      do_reset(1'b0);
      wr(7'h01, 8'h01);
      chk("stabilizer", 12'h001, {11'h0, stab});
      host.xfer({1'b0, 7'h01, 8'h00}, 8, rd_d);
      repeat (10) @(posedge clk_sys);
      chk("partial", 12'h001, {11'h0, stab});
      wr(7'h03, 8'h00);
      rdchk("unmapped", 7'h03, 8'hFF);
      wr(7'h00, 8'h01);
      chk("sleep", 12'h001, {11'h0, sleep});
      for (int n = 0; n < 2; n++) enc_cycle(1'b0);
      wr(7'h00, 8'h00);
      for (int f = 0; f < 4; f++) begin
         fb = {2'b00, f[0], 3'(f + 1), f[1:0]};
         wr(7'h02, fb);
         rdchk("readback", 7'h02, fb);
         chk("lvds", {11'h0, f == 2}, {11'h0, lvds});
         chk("current", {9'h0, fb[4:2]}, {9'h0, cur});
         chk("term", {11'h0, fb[5]}, {11'h0, term});
         exp_fmt = (f == 3) ? 2'h0 : f[1:0];
         for (int n = 0; n < 4; n++) enc_cycle(1'b1);
      end
      // stabilizer on with an output clock delay of two cycles
      wr(7'h01, 8'h05);
      exp_dly = 2;
      for (int n = 0; n < 2; n++) enc_cycle(1'b1);
      exp_dly = 0;
      do_reset(1'b1);
      for (int p = 0; p < 8; p++) begin
         @(negedge clk_sys);
         host.set_par(p[2], p[1], p[0]);
         repeat (10) @(posedge clk_sys);
         chk("par stab", {11'h0, p[2]}, {11'h0, stab});
         chk("par lvds", {11'h0, p[1]}, {11'h0, lvds});
         chk("par current", {9'h0, `ACP_CUR_3P5MA}, {9'h0, cur});
         chk("par sleep", {11'h0, p[0]}, {11'h0, sleep});
         chk("par sdo", 12'h0, {11'h0, sdo_oe});
         exp_fmt = p[1] ? 2'h2 : 2'h0;
         for (int n = 0; n < 2; n++) enc_cycle(!p[0]);
      end
      chk("notes left", 12'h0, 12'(expq.size()));
      give_verdict();
   end
endmodule // acp_top_tb
